/* File: src/vic_params.svh */
// Overview of operation
// - each source has a flag set by its request, cleared only by software
// - each source has an enable; disabled sources are never presented
// - each source has a 3-bit priority field, eight levels
// - on acceptance latch 7-bit vector and 4-bit level into status register
// - latched level equals the programmed priority of the taken source
// - sources map in request order; request 0 uses bit 0 and bits 2:0
// - vector equals request plus eight; lower request wins natural order
// - uart one error is request 65, uart two error request 66
// - nine pwm generator interrupts sit at requests 94 to 102
// - adc pairs 8 to 12 done sit at requests 81 to 85
// - adc pairs 0 to 7 done sit at requests 110 to 117
// - comparators 2, 3, 4 sit at requests 103, 104, 105
// - pwm primary special event is 57, secondary special event is 73
// - position decoder compare events raise requests 58 and 75
// - can transmit data request raises request 70
// - nesting disable stops a running interrupt being pre-empted by users
// - control register a holds trap control bits and sticky trap flags
// - control register b sets external pin edges and alternate table
// - cpu priority low bits reflect level and software may write them
// - cpu priority top bit is read-only to software
// - exactly 27 controller registers are visible to software
// - user interrupts blocked when top bit set or combined level is 7
// - while nesting disable is set, low priority bits are read-only
// - vector address starts 0x14 or 0x114, two units per request
`ifndef VIC_PARAMS_SVH
`define VIC_PARAMS_SVH
`define VIC_NUM_SRC 118
`define VIC_NUM_EXT 5
`define VIC_VEC_OFS 7'h08
`define VIC_PRI_BLOCK 3'h7
`define VIC_IVT_BASE 24'h000014
`define VIC_ALTERNATE_VECTOR_TABLE_BASE 24'h000114
// request numbers of external pins and named sources
`define VIC_SRC_EXT0 0
`define VIC_SRC_EXT1 20
`define VIC_SRC_EXT2 29
`define VIC_SRC_EXT3 53
`define VIC_SRC_EXT4 54
`define VIC_SRC_PWM_PSE 57
`define VIC_SRC_POS1 58
`define VIC_SRC_UART1_ERR 65
`define VIC_SRC_UART2_ERR 66
`define VIC_SRC_CAN_TX 70
`define VIC_SRC_PWM_SSE 73
`define VIC_SRC_POS2 75
`define VIC_SRC_ADC8 81
`define VIC_SRC_PWM_GEN_ONE_IRQ 94
`define VIC_SRC_COMPARATOR_TWO_IRQ 103
`define VIC_SRC_ADC0 110
// register word indices, byte address is four times the index
`define VIC_IDX_CTRL_A 6'h00
`define VIC_IDX_CTRL_B 6'h01
`define VIC_IDX_TAKEN 6'h02
`define VIC_IDX_CPU_PRI 6'h03
`define VIC_IDX_FLAG0 6'h04
`define VIC_IDX_EN0 6'h08
`define VIC_IDX_PRI0 6'h10
`define VIC_NUM_FLAG_W 6'h04
`define VIC_NUM_PRI_W 6'h10
// field positions
`define VIC_A_NEST 15
`define VIC_B_ALT 15
`define VIC_T_LVL_LSB 8
`define VIC_C_LOW_LSB 5
`define VIC_C_TOP 3
`define VIC_A_RSVD_MASK 16'h0001
`define VIC_RESP_OKAY 2'h0
`define VIC_RESP_SLVERR 2'h2
`endif

/* File: src/vic_pkg.sv */
`include "vic_params.svh"
package vic_pkg;
    typedef logic [2:0] vic_pri_t;
    typedef logic [6:0] vic_req_t;

    // reserved request numbers carry no source
    function automatic logic vic_src_valid(input int n);
        logic ok;
        ok = 1'b1;
        if (n == 15 || (n >= 21 && n <= 23) || (n >= 39 && n <= 48))
            ok = 1'b0;
        if ((n >= 51 && n <= 52) || (n >= 55 && n <= 56))
            ok = 1'b0;
        if ((n >= 59 && n <= 64) || (n >= 67 && n <= 69))
            ok = 1'b0;
        if (n == 71 || n == 72 || n == 74 || (n >= 76 && n <= 80))
            ok = 1'b0;
        if ((n >= 86 && n <= 93) || (n >= 106 && n <= 109))
            ok = 1'b0;
        if (n >= `VIC_NUM_SRC)
            ok = 1'b0;
        return ok;
    endfunction

    // which external pin feeds a request, or -1
    function automatic int vic_ext_slot(input int n);
        int s;
        s = -1;
        if (n == `VIC_SRC_EXT0) s = 0;
        if (n == `VIC_SRC_EXT1) s = 1;
        if (n == `VIC_SRC_EXT2) s = 2;
        if (n == `VIC_SRC_EXT3) s = 3;
        if (n == `VIC_SRC_EXT4) s = 4;
        return s;
    endfunction
endpackage

/* File: src/vic_top.sv */
`timescale 1ns/1ps
`include "vic_params.svh"
module vic_top
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // axi4-lite write address
    input wire logic [31:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    // axi4-lite write data
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    // axi4-lite write response
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read
    input wire logic [31:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // peripheral request pulses, one per request number
    input wire logic [`VIC_NUM_SRC-1:0] PERIPH_REQ,
    // external interrupt pins, asynchronous
    input wire logic [`VIC_NUM_EXT-1:0] EXT_PIN,
    // trap events from the core
    input wire logic [6:0] TRAP_EVENT,
    input wire logic TRAP_TAKEN,
    // cpu side
    output logic IRQ_VALID,
    output logic [6:0] IRQ_VECTOR,
    output logic [3:0] IRQ_LEVEL,
    output logic [23:0] IRQ_VECTOR_ADDR,
    input wire logic IRQ_ACK,
    input wire logic IPL_RESTORE_VALID,
    input wire logic [3:0] IPL_RESTORE,
    output logic [3:0] CPU_PRIORITY
);
    localparam int NS = `VIC_NUM_SRC;

    // ********************************
    // bus slave
    // ********************************
    logic aw_held_q, w_held_q, bvalid_q, rvalid_q, aw_ok_q;
    logic [5:0] wr_idx_q;
    logic [31:0] wdata_q, wmask, rdata_q, rd_word;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic wr_fire, rd_fire, rd_ok, wr_ok;

    assign AWREADY = !aw_held_q;
    assign WREADY = !w_held_q;
    assign ARREADY = !rvalid_q;
    assign BVALID = bvalid_q;
    assign BRESP = bresp_q;
    assign RVALID = rvalid_q;
    assign RDATA = rdata_q;
    assign RRESP = rresp_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign rd_fire = ARVALID && !rvalid_q;
    assign wr_ok = (wr_idx_q < (`VIC_IDX_PRI0 + `VIC_NUM_PRI_W))
        && (wr_idx_q < (`VIC_IDX_EN0 + `VIC_NUM_FLAG_W)
        || wr_idx_q >= `VIC_IDX_PRI0);

    genvar b;
    generate
        for (b = 0; b < 4; b++)
        begin : g_mask
            assign wmask[b*8 +: 8] = {8{wstrb_q[b]}};
        end
    endgenerate

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b0;
            aw_ok_q <= 1'b0;
            bresp_q <= `VIC_RESP_OKAY;
            wr_idx_q <= 6'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (AWVALID && !aw_held_q)
            begin
                aw_held_q <= 1'b1;
                wr_idx_q <= AWADDR[7:2];
                // the master may drop the address once taken
                aw_ok_q <= AWADDR[31:8] == 24'h000000;
            end
            if (WVALID && !w_held_q)
            begin
                w_held_q <= 1'b1;
                wdata_q <= WDATA;
                wstrb_q <= WSTRB;
            end
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok && aw_ok_q ?
                    `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
            end
            else if (bvalid_q && BREADY)
            begin
                bvalid_q <= 1'b0;
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `VIC_RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_ok ? rd_word : 32'h00000000;
            rresp_q <= rd_ok ? `VIC_RESP_OKAY : `VIC_RESP_SLVERR;
        end
        else if (RREADY)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // ********************************
    // control, cpu level and taken registers
    // ********************************
    logic [15:0] ctrl_a_q, ctrl_b_q;
    logic [2:0] cpu_low_q;
    logic cpu_top_q;
    logic [6:0] taken_vec_q;
    logic [3:0] taken_lvl_q;
    logic pend_q, ack_fire, nest;
    logic [6:0] vec_q;
    logic [2:0] lvl_q;
    logic [23:0] addr_q;

    assign nest = ctrl_a_q[`VIC_A_NEST];
    assign ack_fire = IRQ_ACK && pend_q;
    assign CPU_PRIORITY = {cpu_top_q, cpu_low_q};

    // trap flags are sticky: a trap in the clearing cycle survives
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            ctrl_a_q <= 16'h0000;
        else if (wr_fire && wr_idx_q == `VIC_IDX_CTRL_A)
            ctrl_a_q <= (((ctrl_a_q & ~wmask[15:0]) | (wdata_q[15:0]
                & wmask[15:0])) | {8'h00, TRAP_EVENT, 1'b0})
                & ~`VIC_A_RSVD_MASK;
        else
            ctrl_a_q <= ctrl_a_q | {8'h00, TRAP_EVENT, 1'b0};
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
            ctrl_b_q <= 16'h0000;
        else if (wr_fire && wr_idx_q == `VIC_IDX_CTRL_B)
            ctrl_b_q <= (ctrl_b_q & ~wmask[15:0])
                | (wdata_q[15:0] & wmask[15:0]);
    end

    // restore from the core beats acceptance, which beats software
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            cpu_low_q <= 3'h0;
            cpu_top_q <= 1'b0;
        end
        else if (IPL_RESTORE_VALID)
        begin
            cpu_low_q <= IPL_RESTORE[2:0];
            cpu_top_q <= IPL_RESTORE[3];
        end
        else if (TRAP_TAKEN)
            cpu_top_q <= 1'b1;
        else if (ack_fire)
            cpu_low_q <= nest ? `VIC_PRI_BLOCK : lvl_q;
        else if (wr_fire && wr_idx_q == `VIC_IDX_CPU_PRI && !nest
            && wstrb_q[0])
            cpu_low_q <= wdata_q[`VIC_C_LOW_LSB +: 3];
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            taken_vec_q <= 7'h00;
            taken_lvl_q <= 4'h0;
        end
        else if (ack_fire)
        begin
            taken_vec_q <= vec_q;
            taken_lvl_q <= {1'b0, lvl_q};
        end
    end

    // ********************************
    // per-source flags, enables, priorities
    // ********************************
    logic [127:0] flag_w, en_w;
    logic [511:0] pri_w;
    logic [`VIC_NUM_SRC-1:0] flag_q, en_q, cand;
    vic_pkg::vic_pri_t pri_q [`VIC_NUM_SRC];
    logic [`VIC_NUM_EXT-1:0] ext_s1_q, ext_s2_q, ext_s3_q, ext_evt;

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            ext_s1_q <= 5'h00;
            ext_s2_q <= 5'h00;
            ext_s3_q <= 5'h00;
        end
        else
        begin
            ext_s1_q <= EXT_PIN;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end
    // polarity bit 0 catches rising edges, 1 falling
    assign ext_evt = (ext_s2_q ^ ctrl_b_q[4:0])
        & ~(ext_s3_q ^ ctrl_b_q[4:0]);

    genvar i;
    generate
        for (i = 0; i < 128; i++)
        begin : g_src
            if (i < NS && vic_pkg::vic_src_valid(i))
            begin : g_live
                localparam int SLOT = vic_pkg::vic_ext_slot(i);
                logic set, wr_f, wr_e, wr_p;
                if (SLOT >= 0)
                begin : g_ext
                    assign set = ext_evt[SLOT];
                end
                else
                begin : g_per
                    assign set = PERIPH_REQ[i];
                end
                assign wr_f = wr_fire && wmask[i%32]
                    && wr_idx_q == 6'(`VIC_IDX_FLAG0 + i/32);
                assign wr_e = wr_fire && wmask[i%32]
                    && wr_idx_q == 6'(`VIC_IDX_EN0 + i/32);
                assign wr_p = wr_fire && wmask[(i%8)*4]
                    && wr_idx_q == 6'(`VIC_IDX_PRI0 + i/8);
                always_ff @(posedge CLK)
                begin
                    if (!RST_N)
                        flag_q[i] <= 1'b0;
                    else if (set)
                        flag_q[i] <= 1'b1;
                    else if (wr_f)
                        flag_q[i] <= wdata_q[i%32];
                end
                always_ff @(posedge CLK)
                begin
                    if (!RST_N)
                        en_q[i] <= 1'b0;
                    else if (wr_e)
                        en_q[i] <= wdata_q[i%32];
                end
                always_ff @(posedge CLK)
                begin
                    if (!RST_N)
                        pri_q[i] <= 3'h0;
                    else if (wr_p)
                        pri_q[i] <= wdata_q[(i%8)*4 +: 3];
                end
                assign flag_w[i] = flag_q[i];
                assign en_w[i] = en_q[i];
                assign pri_w[i*4 +: 4] = {1'b0, pri_q[i]};
                assign cand[i] = flag_q[i] && en_q[i] && !cpu_top_q
                    && cpu_low_q != `VIC_PRI_BLOCK
                    && pri_q[i] > cpu_low_q;
            end
            else if (i < NS)
            begin : g_rsvd
                assign flag_q[i] = 1'b0;
                assign en_q[i] = 1'b0;
                assign pri_q[i] = 3'h0;
                assign flag_w[i] = 1'b0;
                assign en_w[i] = 1'b0;
                assign pri_w[i*4 +: 4] = 4'h0;
                assign cand[i] = 1'b0;
            end
            else
            begin : g_pad
                assign flag_w[i] = 1'b0;
                assign en_w[i] = 1'b0;
                assign pri_w[i*4 +: 4] = 4'h0;
            end
        end
    endgenerate

    // ********************************
    // arbiter and cpu presentation
    // ********************************
    logic found;
    logic [2:0] best_pri;
    logic [6:0] best_idx;

    // walking down means an equal priority at a lower request takes over
    always_comb
    begin
        found = 1'b0;
        best_pri = 3'h0;
        best_idx = 7'h00;
        for (int n = NS - 1; n >= 0; n--)
        begin
            if (cand[n] && (!found || pri_q[n] >= best_pri))
            begin
                found = 1'b1;
                best_pri = pri_q[n];
                best_idx = 7'(n);
            end
        end
    end

    // one quiet cycle after an ack lets the raised cpu level settle
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            pend_q <= 1'b0;
            vec_q <= 7'h00;
            lvl_q <= 3'h0;
            addr_q <= 24'h000000;
        end
        else
        begin
            pend_q <= found && !ack_fire && !IPL_RESTORE_VALID;
            vec_q <= best_idx + `VIC_VEC_OFS;
            lvl_q <= best_pri;
            addr_q <= (ctrl_b_q[`VIC_B_ALT] ? `VIC_ALTERNATE_VECTOR_TABLE_BASE : `VIC_IVT_BASE)
                + {16'h0000, best_idx, 1'b0};
        end
    end
    assign IRQ_VALID = pend_q;
    assign IRQ_VECTOR = vec_q;
    assign IRQ_LEVEL = {1'b0, lvl_q};
    assign IRQ_VECTOR_ADDR = addr_q;

    // ********************************
    // read mux: 27 controller words plus the cpu level word
    // ********************************
    logic [5:0] ri, ro;
    always_comb
    begin
        ri = ARADDR[7:2];
        ro = 6'h00;
        rd_ok = ARADDR[31:8] == 24'h000000;
        rd_word = 32'h00000000;
        if (ri == `VIC_IDX_CTRL_A)
            rd_word = {16'h0000, ctrl_a_q};
        else if (ri == `VIC_IDX_CTRL_B)
            rd_word = {16'h0000, ctrl_b_q};
        else if (ri == `VIC_IDX_TAKEN)
            rd_word = {20'h00000, taken_lvl_q, 1'b0, taken_vec_q};
        else if (ri == `VIC_IDX_CPU_PRI)
            rd_word = {24'h000000, cpu_low_q, 1'b0, cpu_top_q, 3'h0};
        else if (ri < `VIC_IDX_EN0)
        begin
            ro = ri - `VIC_IDX_FLAG0;
            rd_word = flag_w[{ro[1:0], 5'h00} +: 32];
        end
        else if (ri < `VIC_IDX_EN0 + `VIC_NUM_FLAG_W)
        begin
            ro = ri - `VIC_IDX_EN0;
            rd_word = en_w[{ro[1:0], 5'h00} +: 32];
        end
        else if (ri >= `VIC_IDX_PRI0 && ri < `VIC_IDX_PRI0 + `VIC_NUM_PRI_W)
        begin
            ro = ri - `VIC_IDX_PRI0;
            rd_word = pri_w[{ro[3:0], 5'h00} +: 32];
        end
        else
            rd_ok = 1'b0;
    end

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_ack;
        IRQ_ACK && pend_q;
    endsequence
    sequence s_cpu_wr;
        wr_fire && wr_idx_q == `VIC_IDX_CPU_PRI && !IPL_RESTORE_VALID
            && !TRAP_TAKEN && !ack_fire;
    endsequence

    AST_UART_FLAG_SET: assert property (
        PERIPH_REQ[`VIC_SRC_UART1_ERR] |=> flag_q[`VIC_SRC_UART1_ERR])
        else $error("uart error request did not set its flag");
    AST_FLAG_HOLD: assert property (
        flag_q[`VIC_SRC_CAN_TX] && !wr_fire |=> flag_q[`VIC_SRC_CAN_TX])
        else $error("flag dropped without a software write");
    AST_RSVD_EMPTY: assert property (
        !flag_q[15] && !flag_q[`VIC_SRC_PWM_SSE + 1])
        else $error("reserved request flag was set");
    AST_PRESENT_CAUSE: assert property (
        IRQ_VALID |-> $past(en_q[best_idx] && flag_q[best_idx]))
        else $error("presented source was not enabled and flagged");
    AST_VECTOR_ADDR: assert property (
        IRQ_VALID |-> IRQ_VECTOR_ADDR == ($past(ctrl_b_q[`VIC_B_ALT]) ?
        `VIC_ALTERNATE_VECTOR_TABLE_BASE : `VIC_IVT_BASE) + {16'h0000,
        IRQ_VECTOR - `VIC_VEC_OFS, 1'b0})
        else $error("vector address does not match vector number");
    AST_LATCH: assert property (
        s_ack |=> taken_vec_q == $past(vec_q)
        && taken_lvl_q == {1'b0, $past(lvl_q)} && !IRQ_VALID)
        else $error("taken register did not latch vector and level");
    AST_BLOCKED: assert property (
        (cpu_top_q || cpu_low_q == `VIC_PRI_BLOCK) ##1
        (cpu_top_q || cpu_low_q == `VIC_PRI_BLOCK) |-> !IRQ_VALID)
        else $error("user interrupt presented while blocked");
    AST_NEST_RO: assert property (
        s_cpu_wr and nest |=> $stable(cpu_low_q))
        else $error("cpu level written while nesting disabled");
    AST_TOP_RO: assert property (
        s_cpu_wr |=> $stable(cpu_top_q))
        else $error("software changed the top priority bit");
    AST_ABOVE_LEVEL: assert property (
        IRQ_VALID |-> IRQ_LEVEL[2:0] > $past(cpu_low_q))
        else $error("presented priority not above cpu level");
endmodule

/* File: tb/vic_cpu_model.sv */
`timescale 1ns/1ps
// ****************
// cpu acceptance model
// ****************
module vic_cpu_model
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // offer from the controller and ack enable from the test
    input wire logic irq_valid,
    input wire logic ack_on,
    // acceptance pulse
    output logic irq_ack
);
    // one-cycle ack; the offer drops after it, so no double take
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            irq_ack <= 1'b0;
        else
            irq_ack <= irq_valid && ack_on && !irq_ack;
    end
endmodule

/* File: tb/test_vic_top.sv */
`timescale 1ns/1ps
`include "vic_params.svh"
module test_vic_top;
    logic CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ_VALID, IRQ_ACK;
    logic TRAP_TAKEN, IPL_RESTORE_VALID, ack_on, seen_q;
    logic [31:0] AWADDR, WDATA, ARADDR, RDATA, rd_q;
    logic [1:0] BRESP, RRESP, rsp_q;
    logic [3:0] WSTRB, IRQ_LEVEL, CPU_PRIORITY, IPL_RESTORE, lvl_q;
    logic [6:0] TRAP_EVENT, IRQ_VECTOR, vec_q;
    logic [23:0] IRQ_VECTOR_ADDR, adr_q;
    logic [`VIC_NUM_SRC-1:0] PERIPH_REQ;
    logic [`VIC_NUM_EXT-1:0] EXT_PIN;
    int n_errors, checks_done;
    int srcs [13] = '{57, 58, 65, 66, 70, 73, 75, 81, 94, 102, 104, 110, 117};

    vic_top uut
    (
        .CLK, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
        .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
        .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .PERIPH_REQ, .EXT_PIN,
        .TRAP_EVENT, .TRAP_TAKEN, .IRQ_VALID, .IRQ_VECTOR, .IRQ_LEVEL,
        .IRQ_VECTOR_ADDR, .IRQ_ACK, .IPL_RESTORE_VALID, .IPL_RESTORE,
        .CPU_PRIORITY
    );
    vic_cpu_model cpu
    (
        .clk(CLK), .rst_n(RST_N), .irq_valid(IRQ_VALID), .ack_on(ack_on),
        .irq_ack(IRQ_ACK)
    );

    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end

    // ****************
    // bus and stimulus tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // bready and rready stay high, so only valids toggle per transfer
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic done;
        done = 1'b0;
        AWADDR <= a;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        while (!done)
        begin
            @(posedge CLK);
            if (AWVALID && AWREADY)
                AWVALID <= 1'b0;
            if (WVALID && WREADY)
                WVALID <= 1'b0;
            done = BVALID;
            rsp_q = BRESP;
        end
    endtask

    task automatic rd(input logic [31:0] a);
        logic done;
        done = 1'b0;
        ARADDR <= a;
        ARVALID <= 1'b1;
        while (!done)
        begin
            @(posedge CLK);
            if (ARVALID && ARREADY)
                ARVALID <= 1'b0;
            done = RVALID;
            rd_q = RDATA;
            rsp_q = RRESP;
        end
    endtask

    function automatic logic [31:0] fa(input int n);
        return 32'h10 + 32'(4 * (n / 32));
    endfunction

    task automatic src(input int n, input int p, input int e);
        wr(32'h40 + 32'(4 * (n / 8)), 32'(p) << (4 * (n % 8)));
        wr(32'h20 + 32'(4 * (n / 32)), 32'(e) << (n % 32));
    endtask

    task automatic pulse(input int n, input int m);
        logic [`VIC_NUM_SRC-1:0] hit;
        hit = '0;
        hit[n] = 1'b1;
        hit[m] = 1'b1;
        PERIPH_REQ <= hit;
        @(posedge CLK);
        PERIPH_REQ <= '0;
    endtask

    task automatic cpu_priority_low(input logic [3:0] v);
        IPL_RESTORE <= v;
        IPL_RESTORE_VALID <= 1'b1;
        @(posedge CLK);
        IPL_RESTORE_VALID <= 1'b0;
        repeat (3) @(posedge CLK);
    endtask

    // offer latency is two cycles, six edges leave a margin
    task automatic wait_irq();
        seen_q = 1'b0;
        for (int i = 0; i < 6 && !seen_q; i++)
        begin
            @(posedge CLK);
            seen_q = (IRQ_VALID === 1'b1);
            vec_q = IRQ_VECTOR;
            lvl_q = IRQ_LEVEL;
            adr_q = IRQ_VECTOR_ADDR;
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        #400000;
        n_errors++;
        stop_test();
    end

    // ****************
    // test sequence
    // ****************
    initial
    begin
        {AWVALID, WVALID, ARVALID, TRAP_TAKEN, IPL_RESTORE_VALID} = '0;
        {AWADDR, WDATA, ARADDR, PERIPH_REQ, EXT_PIN, TRAP_EVENT} = '0;
        {BREADY, RREADY, WSTRB, IPL_RESTORE, ack_on} = {2'h3, 4'hF, 5'h0};
        RST_N = 1'b0;
        repeat (10) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        rd(32'h0C);
        chk(rd_q, 32'h0);
        rd(32'h30);
        chk({30'h0, rsp_q}, 32'h2);
        rd(32'h7C);
        chk({30'h0, rsp_q}, 32'h0);
        wr(32'h30, 32'h0);
        chk({30'h0, rsp_q}, 32'h2);
        ack_on <= 1'b1;
        src(65, 4, 1);
        pulse(65, 65);
        wait_irq();
        ack_on <= 1'b0;
        chk(32'(vec_q), 32'h49);
        chk(32'(lvl_q), 32'h4);
        chk(32'(adr_q), 32'h96);
        repeat (3) @(posedge CLK);
        rd(32'h08);
        chk(rd_q, 32'h449);
        chk(32'(CPU_PRIORITY), 32'h4);
        rd(32'h18);
        chk(rd_q, 32'h2);
        wr(32'h18, 32'h0);
        rd(32'h18);
        chk(rd_q, 32'h0);
        cpu_priority_low(4'h0);
        foreach (srcs[i])
        begin
            src(srcs[i], 5, 1);
            pulse(srcs[i], srcs[i]);
            wait_irq();
            chk(32'(vec_q), 32'(srcs[i] + 8));
            chk(32'(adr_q), 32'(20 + 2 * srcs[i]));
            wr(fa(srcs[i]), 32'h0);
            src(srcs[i], 0, 0);
        end
        wr(32'h04, 32'h8000);
        src(104, 5, 1);
        pulse(104, 104);
        wait_irq();
        chk(32'(adr_q), 32'h1E4);
        wr(32'h04, 32'h0);
        wr(fa(104), 32'h0);
        // disabled source keeps its flag and is offered once enabled
        src(117, 5, 0);
        pulse(117, 117);
        wait_irq();
        chk(32'(seen_q), 32'h0);
        wr(32'h2C, 32'h0020_0000);
        wait_irq();
        chk(32'(seen_q), 32'h1);
        cpu_priority_low(4'h5);
        wait_irq();
        chk(32'(seen_q), 32'h0);
        cpu_priority_low(4'h8);
        wait_irq();
        chk(32'(seen_q), 32'h0);
        cpu_priority_low(4'h0);
        wr(fa(117), 32'h0);
        src(117, 0, 0);
        wr(32'h6C, 32'h3300_0000);
        wr(32'h28, 32'hC000_0000);
        pulse(94, 95);
        wait_irq();
        chk(32'(vec_q), 32'h66);
        wr(32'h6C, 32'h6300_0000);
        repeat (3) @(posedge CLK);
        wait_irq();
        chk(32'(vec_q), 32'h67);
        wr(32'h18, 32'h0);
        wr(32'h28, 32'h0);
        pulse(60, 60);
        rd(32'h14);
        chk(rd_q, 32'h0);
        src(0, 1, 0);
        EXT_PIN[0] <= 1'b1;
        repeat (6) @(posedge CLK);
        rd(32'h10);
        chk(rd_q, 32'h1);
        rd(32'h40);
        chk(rd_q, 32'h1);
        TRAP_EVENT <= 7'h01;
        @(posedge CLK);
        TRAP_EVENT <= 7'h00;
        rd(32'h00);
        chk(rd_q, 32'h2);
        // with nesting off the taken interrupt raises the cpu level to 7
        wr(32'h00, 32'h8000);
        ack_on <= 1'b1;
        src(65, 2, 1);
        pulse(65, 65);
        wait_irq();
        ack_on <= 1'b0;
        repeat (3) @(posedge CLK);
        chk(32'(CPU_PRIORITY), 32'h7);
        wr(32'h0C, 32'h0);
        rd(32'h0C);
        chk(rd_q, 32'hE0);
        wr(32'h00, 32'h0);
        cpu_priority_low(4'h0);
        wr(32'h0C, 32'hFF);
        rd(32'h0C);
        chk(rd_q, 32'hE0);
        stop_test();
    end
endmodule
